//--- logic/gtg_map.vh
// register map, field positions and reset values of the gated timer block
`ifndef GTG_MAP_VH
`define GTG_MAP_VH

// number of identical timer gate channels
`define GTG_NUM_TIMERS 3

// per-timer window: byte address = timer index * stride + offset
`define GTG_TIMER_STRIDE 16
`define GTG_OFF_GCON 4'h0
`define GTG_OFF_CNTL 4'h4
`define GTG_OFF_CNTH 4'h8
`define GTG_OFF_RUN 4'hC

// shared interrupt registers
`define GTG_ADR_IRQ_STAT 8'h30
`define GTG_ADR_IRQ_MASK 8'h34

// gate_control field positions
`define GTG_GE 7
`define GTG_POL 6
`define GTG_GTM 5
`define GTG_SPM 4
`define GTG_GO 3
`define GTG_GVAL 2
`define GTG_GSS_HI 1
`define GTG_GSS_LO 0

// gate_source_select encodings
`define GTG_GSS_PIN 2'h0
`define GTG_GSS_T0OVF 2'h1
`define GTG_GSS_CMP1 2'h2
`define GTG_GSS_CMP2 2'h3

// run register field
`define GTG_RUN_BIT 0

// interrupt status / mask layout
`define GTG_IRQ_GEV_LSB 0
`define GTG_IRQ_OVF_LSB 4

// reset values
`define GTG_GCON_RST 8'h00
`define GTG_IRQ_RST 8'h00

// count limits and source bus width
`define GTG_CNT_MAX 16'hFFFF
`define GTG_SRC_W 6

`endif

//--- logic/gtg_sync.v
// two-flop synchroniser for the gate source inputs
`timescale 1ns/1ps
module gtg_sync #(
	parameter W = 6
) (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// asynchronous levels in, synchronised levels out
	input wire [W-1:0] async_i,
	output wire [W-1:0] sync_o
);

reg [W-1:0] meta_q;
reg [W-1:0] sync_q;

// first stage feeds only the second stage
always @(posedge clk_i) begin
	if (rst_i) begin
		meta_q <= {W{1'b0}};
		sync_q <= {W{1'b0}};
	end else begin
		meta_q <= async_i;
		sync_q <= meta_q;
	end
end

assign sync_o = sync_q;

endmodule // gtg_sync

//--- logic/gtg_top.v
// three gated 16-bit timer channels with gate control behind classic wishbone
//
// Local design decisions: the Wishbone register port and the address map.
`timescale 1ns/1ps
`include "gtg_map.vh"

module gtg_top (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [31:0] wb_dat_i,
	input wire [3:0] wb_sel_i,
	output wire [31:0] wb_dat_o,
	output wire wb_ack_o,
	// count strobes from the clock/prescaler stage, one per timer
	input wire [2:0] tick_i,
	// gate sources
	input wire [2:0] gate_pin_i,
	input wire t0_ovf_i,
	input wire cmp1_i,
	input wire cmp2_i,
	// status out
	output wire irq_o,
	output wire [2:0] count_en_o,
	output wire [2:0] gate_value_o
);

// decode of one register word, shared by every channel and the irq registers
function hit;
	input [7:0] adr;
	input [7:0] reg_adr;
	begin
		hit = (adr[7:2] == reg_adr[7:2]);
	end
endfunction

// bus handshake state
reg ack_q;
reg [7:0] dat_q;
wire req;
wire wr_en;
wire [7:0] wdat;

// shared interrupt state
reg [7:0] irq_stat_q;
reg [7:0] irq_mask_q;
reg irq_q;
reg [7:0] irq_stat_d;
wire [7:0] irq_events;

// per-channel results gathered for the read mux and irq logic
wire [23:0] rd_t;
wire [2:0] gev_t;
wire [2:0] ovf_t;

// synchronised gate sources: pins [2:0], overflow, cmp1, cmp2
wire [5:0] src_sync;
wire [2:0] pin_s;
wire t0_s;
wire cmp1_s;
wire cmp2_s;

reg [7:0] rd_d;
integer k;

// single-cycle request: ack follows the sampled request by one edge
assign req = wb_cyc_i & wb_stb_i & ~ack_q;
// registers are eight bits wide, so only lane 0 writes
assign wr_en = req & wb_we_i & wb_sel_i[0];
assign wdat = wb_dat_i[7:0];

// all sources go through two flops, comparators included
gtg_sync #(
	.W(`GTG_SRC_W)
) u_sync (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.async_i({cmp2_i, cmp1_i, t0_ovf_i, gate_pin_i}),
	.sync_o(src_sync)
);

assign pin_s = src_sync[2:0];
assign t0_s = src_sync[3];
assign cmp1_s = src_sync[4];
assign cmp2_s = src_sync[5];

genvar i;
generate
	for (i = 0; i < `GTG_NUM_TIMERS; i = i + 1) begin : g_tmr
		localparam integer TBASE_I = i * `GTG_TIMER_STRIDE;
		localparam [7:0] TBASE = TBASE_I[7:0];
		localparam [7:0] A_GCON = TBASE | {4'h0, `GTG_OFF_GCON};
		localparam [7:0] A_CNTL = TBASE | {4'h0, `GTG_OFF_CNTL};
		localparam [7:0] A_CNTH = TBASE | {4'h0, `GTG_OFF_CNTH};
		localparam [7:0] A_RUN = TBASE | {4'h0, `GTG_OFF_RUN};

		// control fields
		reg ge_q;
		reg pol_q;
		reg gtm_q;
		reg spm_q;
		reg go_q;
		reg [1:0] gss_q;
		reg run_q;
		// gate path state
		reg g_prev_q;
		reg tog_q;
		reg tg_prev_q;
		reg open_q;
		reg gval_q;
		reg cnt_en_q;
		// count, no reset: keeps its value through reset
		reg [15:0] cnt_q;

		reg src;
		wire g;
		wire g_rise;
		wire tg;
		wire tg_rise;
		wire tg_fall;
		wire gate_lvl;
		wire cnt_en;
		wire wr_gcon;
		wire wr_cntl;
		wire wr_cnth;
		wire wr_run;
		wire [7:0] gcon_rd;

		assign wr_gcon = wr_en & hit(wb_adr_i, A_GCON);
		assign wr_cntl = wr_en & hit(wb_adr_i, A_CNTL);
		assign wr_cnth = wr_en & hit(wb_adr_i, A_CNTH);
		assign wr_run = wr_en & hit(wb_adr_i, A_RUN);

		// source select
		always @* begin
			case (gss_q)
				`GTG_GSS_PIN: src = pin_s[i];
				`GTG_GSS_T0OVF: src = t0_s;
				`GTG_GSS_CMP1: src = cmp1_s;
				default: src = cmp2_s;
			endcase
		end

		// polarity makes g the active level
		assign g = pol_q ? src : ~src;
		assign g_rise = g & ~g_prev_q;
		// toggle flop output replaces the gate in toggle mode
		assign tg = gtm_q ? tog_q : g;
		assign tg_rise = tg & ~tg_prev_q;
		assign tg_fall = ~tg & tg_prev_q;
		// single pulse only passes the window opened after arming
		assign gate_lvl = spm_q ? (go_q & open_q & tg) : tg;
		// gate only matters while running with gate enable set
		assign cnt_en = run_q & (~ge_q | gval_q);

		// control register writes and hardware clear of the status bit
		always @(posedge clk_i) begin
			if (rst_i) begin
				ge_q <= 1'b0;
				pol_q <= 1'b0;
				gtm_q <= 1'b0;
				spm_q <= 1'b0;
				go_q <= 1'b0;
				gss_q <= 2'h0;
				run_q <= 1'b0;
			end else begin
				if (wr_gcon) begin
					ge_q <= wdat[`GTG_GE];
					pol_q <= wdat[`GTG_POL];
					gtm_q <= wdat[`GTG_GTM];
					spm_q <= wdat[`GTG_SPM];
					// arming only sticks with single-pulse mode on
					go_q <= wdat[`GTG_GO] & wdat[`GTG_SPM];
					gss_q <= wdat[`GTG_GSS_HI:`GTG_GSS_LO];
				end else if (~spm_q) begin
					go_q <= 1'b0;
				end else if (go_q & open_q & tg_fall) begin
					go_q <= 1'b0;
				end
				if (wr_run)
					run_q <= wdat[`GTG_RUN_BIT];
			end
		end

		// edge history, toggle flop, pulse window, latched gate value
		always @(posedge clk_i) begin
			if (rst_i) begin
				g_prev_q <= 1'b0;
				tg_prev_q <= 1'b0;
				tog_q <= 1'b0;
				open_q <= 1'b0;
				gval_q <= 1'b0;
				cnt_en_q <= 1'b0;
			end else begin
				g_prev_q <= g;
				tg_prev_q <= tg;
				if (~gtm_q | ~run_q)
					tog_q <= 1'b0;
				else if (g_rise)
					tog_q <= ~tog_q;
				// window closes whenever the arm is gone; re-arm waits for a new edge
				if (~spm_q | ~go_q)
					open_q <= 1'b0;
				else if (tg_rise)
					open_q <= 1'b1;
				// sampled every cycle, independent of gate enable
				gval_q <= gate_lvl;
				cnt_en_q <= cnt_en;
			end
		end

		// count; a bus write takes precedence over an increment
		always @(posedge clk_i) begin
			if (wr_cntl)
				cnt_q[7:0] <= wdat;
			else if (wr_cnth)
				cnt_q[15:8] <= wdat;
			else if (tick_i[i] & cnt_en)
				cnt_q <= cnt_q + 16'h0001;
		end

		assign ovf_t[i] = tick_i[i] & cnt_en & ~wr_cntl & ~wr_cnth & (cnt_q == `GTG_CNT_MAX);
		// falling edge of the latched gate value, not gated by enable
		assign gev_t[i] = gval_q & ~gate_lvl;

		assign gcon_rd = {ge_q, pol_q, gtm_q, spm_q, go_q, gval_q, gss_q};
		assign rd_t[i*8 +: 8] = hit(wb_adr_i, A_GCON) ? gcon_rd :
			hit(wb_adr_i, A_CNTL) ? cnt_q[7:0] :
			hit(wb_adr_i, A_CNTH) ? cnt_q[15:8] :
			hit(wb_adr_i, A_RUN) ? {7'h00, run_q} : 8'h00;

		assign count_en_o[i] = cnt_en_q;
		assign gate_value_o[i] = gval_q;
	end
endgenerate

// event vector in the status layout; spare bits stay zero
assign irq_events = {1'b0, ovf_t, 1'b0, gev_t};

// write-one-to-clear; a same-cycle event wins over the clear
always @* begin
	irq_stat_d = irq_stat_q;
	if (wr_en & hit(wb_adr_i, `GTG_ADR_IRQ_STAT))
		irq_stat_d = irq_stat_q & ~wdat;
	irq_stat_d = irq_stat_d | irq_events;
end

// read mux: channels decode disjoint words, so OR-ing is safe
always @* begin
	rd_d = 8'h00;
	for (k = 0; k < `GTG_NUM_TIMERS; k = k + 1)
		rd_d = rd_d | rd_t[k*8 +: 8];
	if (hit(wb_adr_i, `GTG_ADR_IRQ_STAT))
		rd_d = irq_stat_q;
	else if (hit(wb_adr_i, `GTG_ADR_IRQ_MASK))
		rd_d = irq_mask_q;
end

// interrupt registers and registered level output
always @(posedge clk_i) begin
	if (rst_i) begin
		irq_stat_q <= `GTG_IRQ_RST;
		irq_mask_q <= `GTG_IRQ_RST;
		irq_q <= 1'b0;
	end else begin
		irq_stat_q <= irq_stat_d;
		if (wr_en & hit(wb_adr_i, `GTG_ADR_IRQ_MASK))
			irq_mask_q <= wdat;
		// one cycle behind the status so the pin comes from a flop
		irq_q <= |(irq_stat_q & irq_mask_q);
	end
end

// bus answer: every address acks, unmapped ones read zero
always @(posedge clk_i) begin
	if (rst_i) begin
		ack_q <= 1'b0;
		dat_q <= 8'h00;
	end else begin
		ack_q <= req;
		if (req & ~wb_we_i)
			dat_q <= rd_d;
	end
end

assign wb_ack_o = ack_q;
assign wb_dat_o = {24'h000000, dat_q};
assign irq_o = irq_q;

endmodule // gtg_top

//--- verification/gtg_src_model.sv
// stand-in for the gate pin, overflow and comparator sources
`timescale 1ns/1ps
module gtg_src_model (
	// clock
	input wire logic clk_i,
	// wanted levels: pins 2:0, overflow, comparator one, two
	input wire logic [5:0] lvl_i,
	// source levels
	output logic [2:0] gate_pin_o,
	output logic t0_ovf_o,
	output logic cmp1_o,
	output logic cmp2_o
);
	// sources move just after an edge, as off-chip logic would
	initial {cmp2_o, cmp1_o, t0_ovf_o, gate_pin_o} = 6'h00;
	always @(posedge clk_i) begin
		{cmp2_o, cmp1_o, t0_ovf_o, gate_pin_o} <= lvl_i;
	end
endmodule // gtg_src_model

//--- verification/gtg_top_checker.sv
// port assertions for the gated timer block
`timescale 1ns/1ps
module gtg_top_checker (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// bus
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [31:0] wb_dat_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	// gate side
	input wire [2:0] gate_pin_i,
	input wire [2:0] count_en_o,
	input wire [2:0] gate_value_o
);
	reg [7:0] g0_q;
	reg r0_q;
	wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wr = req && wb_we_i && wb_sel_i[0];
	wire plain0 = !g0_q[5] && !g0_q[4];
	wire en0 = r0_q && (!g0_q[7] || gate_value_o[0]);
	// shadow of channel 0 setup, so gate checks know the mode
	always @(posedge clk_i) begin
		if (rst_i) begin
			g0_q <= 8'h00;
			r0_q <= 1'b0;
		end else if (wr && wb_adr_i == 8'h00) begin
			g0_q <= wb_dat_i[7:0];
		end else if (wr && wb_adr_i == 8'h0C) begin
			r0_q <= wb_dat_i[0];
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ack_one;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack too long");
	property p_ack_req;
		req |=> wb_ack_o;
	endproperty
	a_ack_req: assert property (p_ack_req) else $error("ack missing");
	property p_no_req;
		!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
	endproperty
	a_no_req: assert property (p_no_req) else $error("ack unasked");
	property p_rd_hold;
		!(req && !wb_we_i) |=> $stable(wb_dat_o);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	property p_dat_hi;
		wb_ack_o |-> wb_dat_o[31:8] == 24'h0;
	endproperty
	a_dat_hi: assert property (p_dat_hi) else $error("upper read bits set");
	// reset is the antecedent here, so the default disable is lifted
	property p_rst;
		disable iff (1'b0) rst_i |=> count_en_o == 3'h0 && gate_value_o == 3'h0;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared");
	property p_gval;
		($stable(gate_pin_i[0]) && $stable(g0_q) && plain0 && g0_q[1:0] == 2'h0) [*4]
			|-> gate_value_o[0] == (gate_pin_i[0] ~^ g0_q[6]);
	endproperty
	a_gval: assert property (p_gval) else $error("gate value wrong");
	property p_cnt_en;
		$past(plain0) |-> count_en_o[0] == $past(en0);
	endproperty
	a_cnt_en: assert property (p_cnt_en) else $error("count enable wrong");
endmodule // gtg_top_checker
bind gtg_top gtg_top_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
	.wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.gate_pin_i(gate_pin_i), .count_en_o(count_en_o), .gate_value_o(gate_value_o));

//--- verification/gtg_top_tb.sv
// self-checking bench for the gated timer block
`timescale 1ns/1ps
module gtg_top_tb;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
	logic [7:0] adr = 8'h00, rd;
	logic [31:0] dat = 32'h0;
	logic [2:0] tick = 3'h0;
	logic [5:0] lvl = 6'h00;
	wire [31:0] wb_dat_o;
	wire wb_ack_o, irq_o, t0_ovf, cmp1, cmp2;
	wire [2:0] count_en_o, gate_value_o, pin;
	integer seed = 32'hE391, n_mismatch = 0, num_checks = 0, i, j, p;
	always #25 clk_i = ~clk_i;
	// random strobes keep the counters busy
	always @(posedge clk_i) tick <= $random(seed);
	gtg_src_model u_src (.clk_i(clk_i), .lvl_i(lvl), .gate_pin_o(pin), .t0_ovf_o(t0_ovf),
		.cmp1_o(cmp1), .cmp2_o(cmp2));
	gtg_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'h1), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .tick_i(tick), .gate_pin_i(pin), .t0_ovf_i(t0_ovf),
		.cmp1_i(cmp1), .cmp2_i(cmp2), .irq_o(irq_o), .count_en_o(count_en_o),
		.gate_value_o(gate_value_o));
	function logic exp_gval(input logic lv, input logic pol);
		return lv ~^ pol;
	endfunction
	function logic [5:0] src_mask(input integer s);
		return s == 0 ? 6'h01 : 6'(1 << (s + 2));
	endfunction
	task stop_test;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one classic cycle, held until ack is seen at an edge
	task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		integer k;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {24'h0, d};
		@(posedge clk_i);
		for (k = 0; k < 20 && wb_ack_o !== 1'b1; k++) @(posedge clk_i);
		// a bus that never answers counts against the run
		if (wb_ack_o !== 1'b1) n_mismatch++;
		rd = wb_dat_o[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask
	task pulse;
		lvl <= 6'h01;
		repeat (6) @(posedge clk_i);
		lvl <= 6'h00;
		repeat (6) @(posedge clk_i);
	endtask
	// the watchdog allows far more than the sequence needs
	initial begin
		#(50 * 5000);
		n_mismatch++;
		stop_test;
	end
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		for (i = 0; i < 3; i++) begin
			wb(0, 8'(i * 16), 0);
			chk(rd & 8'hFB, 8'h00);
			j = $random(seed);
			wb(1, 8'(i * 16 + 4), j[7:0]);
			wb(1, 8'(i * 16 + 8), j[15:8]);
			wb(0, 8'(i * 16 + 4), 0);
			chk(rd, j[7:0]);
			wb(0, 8'(i * 16 + 8), 0);
			chk(rd, j[15:8]);
		end
		wb(0, 8'h3C, 0);
		chk(rd, 8'h00);
		$display("test registers done");
		for (i = 0; i < 4; i++) begin
			p = $random(seed);
			wb(1, 8'h00, {1'b0, p[0], 4'h0, 2'(i)});
			for (j = 0; j < 2; j++) begin
				lvl <= j ? src_mask(i) : ~src_mask(i);
				repeat (6) @(posedge clk_i);
				chk(gate_value_o[0], exp_gval(j[0], p[0]));
				wb(0, 8'h00, 0);
				chk(rd[2], exp_gval(j[0], p[0]));
			end
		end
		$display("test sources done");
		lvl <= 6'h00;
		wb(1, 8'h00, 8'hC0);
		wb(1, 8'h04, 8'h00);
		wb(1, 8'h0C, 8'h01);
		repeat (20) @(posedge clk_i);
		wb(0, 8'h04, 0);
		chk(rd, 8'h00);
		lvl <= 6'h01;
		repeat (30) @(posedge clk_i);
		wb(0, 8'h04, 0);
		chk(rd != 8'h00, 8'h01);
		wb(1, 8'h0C, 8'h00);
		wb(0, 8'h04, 0);
		p = rd;
		repeat (10) @(posedge clk_i);
		wb(0, 8'h04, 0);
		chk(rd, p[7:0]);
		$display("test counting done");
		wb(1, 8'h30, 8'hFF);
		wb(1, 8'h34, 8'h01);
		lvl <= 6'h00;
		repeat (6) @(posedge clk_i);
		chk(irq_o, 1);
		wb(1, 8'h34, 8'h00);
		chk(irq_o, 0);
		wb(1, 8'h30, 8'h01);
		wb(0, 8'h30, 0);
		chk(rd[0], 0);
		$display("test interrupt done");
		wb(1, 8'h00, 8'h58);
		wb(0, 8'h00, 0);
		chk(rd[3], 1);
		pulse;
		wb(0, 8'h00, 0);
		chk(rd[3], 0);
		wb(1, 8'h00, 8'h58);
		wb(1, 8'h00, 8'h40);
		wb(0, 8'h00, 0);
		chk(rd[3], 0);
		$display("test single pulse done");
		wb(1, 8'h0C, 8'h01);
		wb(1, 8'h00, 8'h60);
		for (i = 1; i < 4; i++) begin
			pulse;
			chk(gate_value_o[0], i[0]);
		end
		wb(1, 8'h00, 8'h40);
		repeat (4) @(posedge clk_i);
		chk(gate_value_o[0], 0);
		$display("test toggle done");
		// toggle plus single pulse: the arm spans two gate pulses, one full period
		wb(1, 8'h00, 8'h78);
		pulse;
		wb(0, 8'h00, 0);
		chk(rd[3], 1);
		pulse;
		wb(0, 8'h00, 0);
		chk(rd[3], 0);
		$display("test period done");
		stop_test;
	end
endmodule // gtg_top_tb
